// File: hdl/tube_map.svh
// Register offsets, field positions, reset values and fixed levels
`ifndef TUBE_MAP_SVH
`define TUBE_MAP_SVH

// Register byte offsets
`define TM_OFF_CTRL 8'h00
`define TM_OFF_GAIN 8'h04
`define TM_OFF_START 8'h08
`define TM_OFF_AMPL 8'h0c
`define TM_OFF_CUT_SET 8'h10
`define TM_OFF_WHITE_SET 8'h1c
`define TM_OFF_BCL_THR 8'h28
`define TM_OFF_BCL_LIM 8'h2c
`define TM_OFF_MEAS_CUT 8'h30
`define TM_OFF_MEAS_WHITE 8'h3c
`define TM_OFF_CUT_VAL 8'h48
`define TM_OFF_DRIVE_VAL 8'h54
`define TM_OFF_STATUS 8'h60

// Control register bits
`define TM_CTRL_BLACK_DIS 0
`define TM_CTRL_WHITE_DIS 1
`define TM_CTRL_SAT_AVOID 2
`define TM_CTRL_ALT_SENSE 3

// Field positions
`define TM_GAIN_BLACK_LSB 0
`define TM_GAIN_WHITE_LSB 8
`define TM_AMPL_BLACK_LSB 0
`define TM_AMPL_DRIVE_LSB 8
`define TM_AMPL_UPPER_LSB 16
`define TM_BCL_THR_LSB 0
`define TM_BCL_GAIN_LSB 16
`define TM_BCL_TC_LSB 24
`define TM_LIM_CMIN_LSB 0
`define TM_LIM_BMIN_LSB 8
`define TM_LIM_BNOM_LSB 16
`define TM_STAT_OVER 8
`define TM_STAT_MEAS 9
`define TM_STAT_AVG_LSB 16

// Reset values
`define TM_RST_CTRL 32'h0000_0000
`define TM_RST_GAIN 32'h0000_0000
`define TM_RST_START 32'h0000_0010
`define TM_RST_AMPL 32'h01f4_4010
`define TM_RST_BCL_THR 32'h0404_0800
`define TM_RST_BCL_LIM 32'h0080_2040
`define TM_RST_SET 9'h100

// Writable bits per register
`define TM_MASK_CTRL 32'h0000_000f
`define TM_MASK_GAIN 32'h0000_0f0f
`define TM_MASK_START 32'h0000_03ff
`define TM_MASK_AMPL 32'h01ff_ffff
`define TM_MASK_BCL_THR 32'h0f0f_0fff
`define TM_MASK_BCL_LIM 32'h00ff_ffff

// Loop levels: 8 of 511 is the 1.5 percent band
`define TM_HYST 11'sd8
`define TM_DRIVE_MAX 11'sd511
`define TM_DRIVE_LOW 9'd475
`define TM_COLOURS 3

// One-pole average, about 3 kHz at one sample per 25 ns clock
`define TM_AVG_SHIFT 11

`endif

// File: hdl/tube_pkg.sv
// Types shared by the tube measurement and control logic
package tube_pkg;

	typedef logic [2:0][8:0] rgb9_t;
	typedef logic [2:0][7:0] rgb8_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;

	typedef enum logic [1:0] {
		PH_PICTURE,
		PH_BLANK,
		PH_CUTOFF,
		PH_WHITE
	} phase_t;

	typedef struct packed {
		rgb9_t cutoff;
		rgb9_t drive;
		logic measure_line;
		logic white_line;
		logic [1:0] line_colour;
		logic [8:0] line_amplitude;
		logic [7:0] contrast;
		logic [7:0] brightness;
	} video_ctrl_t;

	typedef struct packed {
		phase_t phase;
		logic [9:0] line;
		logic [1:0] colour;
		logic [1:0] wcol;
		logic [7:0] sample;
		logic [31:0] ctrl;
		logic [31:0] gain;
		logic [31:0] start;
		logic [31:0] ampl;
		logic [31:0] bcl_thr;
		logic [31:0] bcl_lim;
		rgb9_t cut_set;
		rgb9_t white_set;
		rgb8_t meas_cut;
		rgb8_t meas_white;
		rgb9_t cut_val;
		rgb9_t drive_val;
		logic [7:0] sat_ofs;
		logic overflow;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		axi_rsp_t rsp;
		video_ctrl_t vid;
		logic range_switch_one;
		logic range_switch_one_oe;
		logic range_switch_two;
		logic alt_sel;
	} tube_state_t;

	typedef struct packed {
		logic [22:0] avg_acc;
		logic [27:0] lim_acc;
	} limiter_state_t;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: hdl/beam_limiter_filter.sv
// Beam current averaging and excess low-pass filter
`timescale 1ns/10ps
`include "tube_map.svh"
module beam_limiter_filter (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [11:0] sample_in,
	input wire logic sample_valid_in,
	input wire logic hold_in,
	input wire logic [11:0] threshold_in,
	input wire logic [3:0] gain_in,
	input wire logic [3:0] time_const_in,
	output logic [11:0] average_out,
	output logic [11:0] excess_out
);
	import tube_pkg::*;

	limiter_state_t s;
	limiter_state_t next_s;

	// Average, then filter the part above threshold
	always_comb begin
		logic signed [24:0] d;
		logic signed [28:0] e;
		logic [11:0] avg;
		logic [11:0] over;
		logic [15:0] scaled;
		logic [11:0] target;
		d = '0;
		e = '0;
		next_s = s;
		avg = s.avg_acc[22:11];
		over = (avg > threshold_in) ? avg - threshold_in : 12'h000;
		scaled = 16'(over) * 16'(gain_in);
		target = (|scaled[15:12]) ? 12'hfff : scaled[11:0];
		// Frozen while measurement lines run
		if (sample_valid_in && !hold_in) begin
			d = $signed({2'b00, sample_in, 11'h000})
				- $signed({2'b00, s.avg_acc});
			next_s.avg_acc = 23'(s.avg_acc
				+ 23'(d >>> `TM_AVG_SHIFT));
			e = $signed({1'b0, target, 16'h0000})
				- $signed({1'b0, s.lim_acc});
			next_s.lim_acc = 28'(s.lim_acc
				+ 28'(e >>> time_const_in));
		end
	end

	// State register
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign average_out = s.avg_acc[22:11];
	assign excess_out = s.lim_acc[27:16];
endmodule

// File: hdl/tube_measure_control_loop.sv
// Tube cutoff and white drive loops, beam limiter, register slave
`timescale 1ns/10ps
`include "tube_map.svh"
module tube_measure_control_loop (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire tube_pkg::axi_req_t axi_req_in,
	output tube_pkg::axi_rsp_t axi_rsp_out,
	input wire logic field_start_in,
	input wire logic line_start_in,
	input wire logic active_picture_in,
	input wire logic [11:0] adc_sample_in,
	input wire logic adc_valid_in,
	output tube_pkg::video_ctrl_t video_ctrl_out,
	output logic range_switch_one_out,
	output logic range_switch_one_oe_out,
	output logic range_switch_two_out,
	output logic adc_alt_select_out
);
	import tube_pkg::*;

	tube_state_t s;
	tube_state_t next_s;
	logic [11:0] beam_avg;
	logic [11:0] beam_excess;
	logic lim_hold;
	logic lim_valid;

	// Byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	// One loop correction step, signed so overflow stays visible
	function automatic logic signed [10:0] loop_step(input logic [8:0] cur,
		input logic [8:0] ref_val, input logic [7:0] meas,
		input logic [3:0] gain);
		logic signed [10:0] err;
		logic signed [10:0] r;
		err = $signed({2'b00, ref_val}) - $signed({2'b00, meas, 1'b0});
		r = $signed({2'b00, cur});
		if (err > `TM_HYST) begin
			r = r + $signed({7'h00, gain});
		end else if (err < -`TM_HYST) begin
			r = r - $signed({7'h00, gain});
		end
		return r;
	endfunction

	// Limit to the 9-bit converter range
	function automatic logic [8:0] clamp9(input logic signed [10:0] v);
		if (v < 0) begin
			return 9'h000;
		end else if (v > `TM_DRIVE_MAX) begin
			return 9'h1ff;
		end
		return v[8:0];
	endfunction

	// Address decode for reads and write responses: {hit, data}
	function automatic logic [32:0] read_word(input tube_state_t st,
		input logic [7:0] a, input logic [11:0] avg);
		logic [32:0] r;
		r = '0;
		case (a)
			`TM_OFF_CTRL: r = {1'b1, st.ctrl};
			`TM_OFF_GAIN: r = {1'b1, st.gain};
			`TM_OFF_START: r = {1'b1, st.start};
			`TM_OFF_AMPL: r = {1'b1, st.ampl};
			`TM_OFF_BCL_THR: r = {1'b1, st.bcl_thr};
			`TM_OFF_BCL_LIM: r = {1'b1, st.bcl_lim};
			`TM_OFF_STATUS: begin
				r[32] = 1'b1;
				r[7:0] = st.sat_ofs;
				r[`TM_STAT_OVER] = st.overflow;
				r[`TM_STAT_MEAS] = st.vid.measure_line;
				r[`TM_STAT_AVG_LSB +: 12] = avg;
			end
			default: r = '0;
		endcase
		for (int k = 0; k < `TM_COLOURS; k++) begin
			if (a == `TM_OFF_CUT_SET + 8'(4 * k)) begin
				r = {1'b1, 23'h0, st.cut_set[k]};
			end
			if (a == `TM_OFF_WHITE_SET + 8'(4 * k)) begin
				r = {1'b1, 23'h0, st.white_set[k]};
			end
			if (a == `TM_OFF_MEAS_CUT + 8'(4 * k)) begin
				r = {1'b1, 24'h0, st.meas_cut[k]};
			end
			if (a == `TM_OFF_MEAS_WHITE + 8'(4 * k)) begin
				r = {1'b1, 24'h0, st.meas_white[k]};
			end
			if (a == `TM_OFF_CUT_VAL + 8'(4 * k)) begin
				r = {1'b1, 23'h0, st.cut_val[k]};
			end
			if (a == `TM_OFF_DRIVE_VAL + 8'(4 * k)) begin
				r = {1'b1, 23'h0, st.drive_val[k]};
			end
		end
		return r;
	endfunction

	// Limiter runs on picture samples and stops during measurement
	assign lim_hold = (s.phase == PH_CUTOFF) || (s.phase == PH_WHITE);
	assign lim_valid = adc_valid_in && (s.phase == PH_PICTURE);

	beam_limiter_filter limiter (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.sample_in(adc_sample_in),
		.sample_valid_in(lim_valid),
		.hold_in(lim_hold),
		.threshold_in(s.bcl_thr[`TM_BCL_THR_LSB +: 12]),
		.gain_in(s.bcl_thr[`TM_BCL_GAIN_LSB +: 4]),
		.time_const_in(s.bcl_thr[`TM_BCL_TC_LSB +: 4]),
		.average_out(beam_avg),
		.excess_out(beam_excess)
	);

	// Next-state logic for bus, sequencer, loops and outputs
	always_comb begin
		logic [32:0] rd;
		logic [31:0] wtmp;
		logic [3:0] bgain;
		logic [3:0] wgain;
		logic bdis;
		logic wdis;
		logic signed [10:0] raw;
		logic any_hi;
		logic any_lo;
		logic [9:0] amp;
		logic [8:0] head;
		logic [8:0] deficit;
		logic [8:0] bnom;
		logic [8:0] bmin;
		logic [8:0] cmin;
		rd = '0;
		wtmp = '0;
		raw = '0;
		any_hi = 1'b0;
		any_lo = 1'b0;
		amp = '0;
		deficit = '0;
		next_s = s;
		bgain = s.gain[`TM_GAIN_BLACK_LSB +: 4];
		wgain = s.gain[`TM_GAIN_WHITE_LSB +: 4];
		bdis = s.ctrl[`TM_CTRL_BLACK_DIS];
		wdis = s.ctrl[`TM_CTRL_WHITE_DIS];

		// Bus: address and data accepted in either order
		next_s.rsp.bvalid = s.rsp.bvalid && !axi_req_in.bready;
		next_s.rsp.rvalid = s.rsp.rvalid && !axi_req_in.rready;
		if (axi_req_in.awvalid && s.rsp.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = {axi_req_in.awaddr[7:2], 2'b00};
		end
		if (axi_req_in.wvalid && s.rsp.wready) begin
			next_s.w_held = 1'b1;
			next_s.w_data = axi_req_in.wdata;
			next_s.w_strb = axi_req_in.wstrb;
		end
		if (s.aw_held && s.w_held) begin
			rd = read_word(s, s.aw_addr, beam_avg);
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
			case (s.aw_addr)
				`TM_OFF_CTRL: next_s.ctrl = wmerge(s.ctrl, s.w_data,
					s.w_strb) & `TM_MASK_CTRL;
				`TM_OFF_GAIN: next_s.gain = wmerge(s.gain, s.w_data,
					s.w_strb) & `TM_MASK_GAIN;
				`TM_OFF_START: next_s.start = wmerge(s.start, s.w_data,
					s.w_strb) & `TM_MASK_START;
				`TM_OFF_AMPL: next_s.ampl = wmerge(s.ampl, s.w_data,
					s.w_strb) & `TM_MASK_AMPL;
				`TM_OFF_BCL_THR: next_s.bcl_thr = wmerge(s.bcl_thr,
					s.w_data, s.w_strb) & `TM_MASK_BCL_THR;
				`TM_OFF_BCL_LIM: next_s.bcl_lim = wmerge(s.bcl_lim,
					s.w_data, s.w_strb) & `TM_MASK_BCL_LIM;
				default: ;
			endcase
			for (int k = 0; k < `TM_COLOURS; k++) begin
				if (s.aw_addr == `TM_OFF_CUT_SET + 8'(4 * k)) begin
					wtmp = wmerge({23'h0, s.cut_set[k]}, s.w_data, s.w_strb);
					next_s.cut_set[k] = wtmp[8:0];
				end
				if (s.aw_addr == `TM_OFF_WHITE_SET + 8'(4 * k)) begin
					wtmp = wmerge({23'h0, s.white_set[k]}, s.w_data,
						s.w_strb);
					next_s.white_set[k] = wtmp[8:0];
				end
			end
		end
		next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
		next_s.rsp.wready = !next_s.w_held && !next_s.rsp.bvalid;
		if (axi_req_in.arvalid && s.rsp.arready) begin
			rd = read_word(s, {axi_req_in.araddr[7:2], 2'b00}, beam_avg);
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata = rd[31:0];
			next_s.rsp.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		next_s.rsp.arready = !next_s.rsp.rvalid;

		// User mode: settings drive the converters directly
		if (bgain == 4'h0) begin
			next_s.cut_val = s.cut_set;
		end
		if (wgain == 4'h0) begin
			next_s.drive_val = s.white_set;
		end

		// Line count and 8-bit measurement sample
		if (line_start_in) begin
			next_s.line = s.line + 10'h001;
		end
		if (adc_valid_in && lim_hold) begin
			next_s.sample = adc_sample_in[11:4];
		end

		// Measurement sequencer in vertical blanking
		case (s.phase)
			PH_PICTURE: begin
				if (!active_picture_in) begin
					next_s.phase = PH_BLANK;
				end
			end
			PH_BLANK: begin
				if (line_start_in && next_s.line == s.start[9:0]) begin
					next_s.colour = 2'd0;
					if (!bdis) begin
						next_s.phase = PH_CUTOFF;
					end else if (!wdis) begin
						next_s.phase = PH_WHITE;
					end
				end else if (active_picture_in) begin
					next_s.phase = PH_PICTURE;
				end
			end
			PH_CUTOFF: begin
				if (line_start_in) begin
					next_s.meas_cut[s.colour] = s.sample;
					if (bgain != 4'h0 && !bdis) begin
						raw = loop_step(s.cut_val[s.colour],
							s.cut_set[s.colour], s.sample, bgain);
						next_s.cut_val[s.colour] = clamp9(raw);
					end
					if (s.colour == 2'd2) begin
						next_s.colour = 2'd0;
						next_s.phase = wdis ? PH_BLANK : PH_WHITE;
					end else begin
						next_s.colour = s.colour + 2'd1;
					end
				end
			end
			PH_WHITE: begin
				if (line_start_in) begin
					next_s.meas_white[s.wcol] = s.sample;
					if (wgain != 4'h0 && !wdis) begin
						raw = loop_step(s.drive_val[s.wcol],
							s.white_set[s.wcol], s.sample, wgain);
						next_s.drive_val[s.wcol] = clamp9(raw);
						next_s.overflow = raw > `TM_DRIVE_MAX;
					end
					for (int k = 0; k < `TM_COLOURS; k++) begin
						if (next_s.drive_val[k]
							> s.ampl[`TM_AMPL_UPPER_LSB +: 9]) begin
							any_hi = 1'b1;
						end
						if (next_s.drive_val[k] < `TM_DRIVE_LOW) begin
							any_lo = 1'b1;
						end
					end
					// Saturation avoidance steps the white line offset
					if (s.ctrl[`TM_CTRL_SAT_AVOID]) begin
						if (any_hi && s.sat_ofs != 8'hff) begin
							next_s.sat_ofs = s.sat_ofs + 8'h01;
						end else if (any_lo && s.sat_ofs != 8'h00) begin
							next_s.sat_ofs = s.sat_ofs - 8'h01;
						end
					end
					next_s.wcol = (s.wcol == 2'd2) ? 2'd0
						: s.wcol + 2'd1;
					next_s.phase = PH_BLANK;
				end
			end
			default: next_s.phase = PH_BLANK;
		endcase
		if (field_start_in) begin
			next_s.line = 10'h000;
			next_s.colour = 2'd0;
			next_s.phase = PH_BLANK;
		end

		// Measurement line drive level
		if (next_s.phase == PH_WHITE) begin
			amp = 10'(s.ampl[`TM_AMPL_BLACK_LSB +: 8])
				+ 10'(s.ampl[`TM_AMPL_DRIVE_LSB +: 8])
				+ 10'(next_s.sat_ofs);
		end else if (next_s.phase == PH_CUTOFF) begin
			amp = 10'(s.ampl[`TM_AMPL_BLACK_LSB +: 8]);
		end
		next_s.vid.line_amplitude = amp[9] ? 9'h1ff : amp[8:0];
		next_s.vid.measure_line = (next_s.phase == PH_CUTOFF)
			|| (next_s.phase == PH_WHITE);
		next_s.vid.white_line = next_s.phase == PH_WHITE;
		next_s.vid.line_colour = (next_s.phase == PH_WHITE) ? next_s.wcol
			: next_s.colour;
		next_s.vid.cutoff = next_s.cut_val;
		next_s.vid.drive = next_s.drive_val;

		// Limiter: contrast down to its floor, then brightness
		cmin = {1'b0, s.bcl_lim[`TM_LIM_CMIN_LSB +: 8]};
		bmin = {1'b0, s.bcl_lim[`TM_LIM_BMIN_LSB +: 8]};
		bnom = {1'b0, s.bcl_lim[`TM_LIM_BNOM_LSB +: 8]};
		head = 9'h0ff - {1'b0, beam_excess[11:4]};
		if (head >= cmin) begin
			next_s.vid.contrast = head[7:0];
			next_s.vid.brightness = bnom[7:0];
		end else begin
			deficit = cmin - head;
			next_s.vid.contrast = cmin[7:0];
			next_s.vid.brightness = (bnom > 9'(bmin + deficit))
				? 8'(bnom - deficit) : bmin[7:0];
		end

		// Range switches and sense selection
		next_s.range_switch_one_oe = !s.ctrl[`TM_CTRL_ALT_SENSE];
		next_s.alt_sel = s.ctrl[`TM_CTRL_ALT_SENSE]
			&& next_s.phase == PH_PICTURE;
		next_s.range_switch_one = next_s.phase == PH_PICTURE;
		next_s.range_switch_two = (next_s.phase == PH_PICTURE)
			|| (next_s.phase == PH_WHITE);
	end

	// State register with synchronous reset
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			s <= '0;
			s.phase <= PH_BLANK;
			s.ctrl <= `TM_RST_CTRL;
			s.gain <= `TM_RST_GAIN;
			s.start <= `TM_RST_START;
			s.ampl <= `TM_RST_AMPL;
			s.bcl_thr <= `TM_RST_BCL_THR;
			s.bcl_lim <= `TM_RST_BCL_LIM;
			s.cut_set <= {3{`TM_RST_SET}};
			s.white_set <= {3{`TM_RST_SET}};
			s.range_switch_one_oe <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign axi_rsp_out = s.rsp;
	assign video_ctrl_out = s.vid;
	assign range_switch_one_out = s.range_switch_one;
	assign range_switch_one_oe_out = s.range_switch_one_oe;
	assign range_switch_two_out = s.range_switch_two;
	assign adc_alt_select_out = s.alt_sel;
endmodule

// File: tb/tube_monitor.sv
// Checker for the measurement line walk, range switches and bus answers
`timescale 1ns/10ps
module tube_monitor (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire tube_pkg::axi_req_t axi_req_in,
	input wire tube_pkg::axi_rsp_t axi_rsp_out,
	input wire logic field_start_in,
	input wire logic line_start_in,
	input wire logic active_picture_in,
	input wire tube_pkg::video_ctrl_t video_ctrl_out,
	input wire logic range_switch_one_out,
	input wire logic range_switch_one_oe_out,
	input wire logic range_switch_two_out,
	input wire logic adc_alt_select_out
);
	import tube_pkg::*;
	logic ml;
	logic wl;
	logic [1:0] lc;
	// Short names for the line flags
	assign ml = video_ctrl_out.measure_line;
	assign wl = video_ctrl_out.white_line;
	assign lc = video_ctrl_out.line_colour;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Line ends inside the cutoff lines, before and at blue
	sequence s_cut_mid;
		line_start_in && !field_start_in && ml && !wl && lc != 2'h2;
	endsequence
	sequence s_cut_blue;
		line_start_in && !field_start_in && ml && !wl && lc == 2'h2;
	endsequence
	a_cut_step: assert property (s_cut_mid
		|=> ml && lc == $past(lc) + 2'h1)
		else $error("cutoff colour did not advance");
	a_cut_white: assert property (s_cut_blue |=> ml && wl)
		else $error("white line did not follow blue cutoff");
	a_white_end: assert property (line_start_in && wl |=> !ml)
		else $error("white line did not end");
	a_field_abort: assert property (field_start_in |=> !ml)
		else $error("measurement ran past field start");
	a_white_range: assert property (wl |-> range_switch_two_out)
		else $error("second switch off in white line");
	a_cut_range: assert property (ml && !wl |-> !range_switch_two_out)
		else $error("second switch on in cutoff line");
	a_picture_range: assert property (active_picture_in && !ml
		|=> range_switch_one_out && range_switch_two_out)
		else $error("widest range not selected in picture");
	a_limiter_off: assert property (ml |-> !range_switch_one_out)
		else $error("picture range during measurement");
	a_alt_input: assert property (adc_alt_select_out
		|-> !range_switch_one_oe_out)
		else $error("switch one driven while used as input");
	a_bresp_hold: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
		|=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
		|=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
		else $error("read data dropped early");
	a_ready_gap: assert property (axi_rsp_out.bvalid
		|-> !axi_rsp_out.awready && !axi_rsp_out.wready)
		else $error("write accepted with response pending");
endmodule
bind tube_measure_control_loop tube_monitor mon (.core_clk_in, .sys_rst_in,
	.axi_req_in, .axi_rsp_out, .field_start_in, .line_start_in,
	.active_picture_in, .video_ctrl_out, .range_switch_one_out,
	.range_switch_one_oe_out, .range_switch_two_out, .adc_alt_select_out);

// File: tb/sense_network_model.sv
// Sense network model: line currents and beam current for the converter
`timescale 1ns/10ps
module sense_network_model (
	input wire logic core_clk_in,
	input wire tube_pkg::video_ctrl_t video_in,
	input wire logic range_one_in,
	input wire logic range_two_in,
	output logic [11:0] sample_out,
	output logic valid_out
);
	import tube_pkg::*;
	logic [11:0] noise = 12'h5a5;
	// One sample per clock; idle lines give a changing pattern
	always @(posedge core_clk_in) begin
		valid_out <= 1'b1;
		noise <= noise + 12'h3c7;
		if (range_one_in && range_two_in) begin
			sample_out <= 12'hfff;
		end else if (video_in.measure_line) begin
			sample_out <= {video_in.white_line,
				{1'b0, video_in.line_colour} + 3'h1, 8'h03};
		end else begin
			sample_out <= noise;
		end
	end
endmodule

// File: tb/tb_top.sv
// Testbench for the tube measurement and control loop
`timescale 1ns/10ps
`include "tube_map.svh"
module tb_top;
	import tube_pkg::*;
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	axi_req_t axi_req_in = '0;
	axi_rsp_t axi_rsp_out;
	logic field_start_in = 1'b0;
	logic line_start_in = 1'b0;
	logic active_picture_in = 1'b0;
	logic [11:0] adc_sample_in;
	logic adc_valid_in;
	video_ctrl_t video_ctrl_out;
	logic range_switch_one_out;
	logic range_switch_one_oe_out;
	logic range_switch_two_out;
	logic adc_alt_select_out;
	int mismatches = 0;
	int checked = 0;
	logic [1:0] wc = 2'h0;
	logic [31:0] rd;
	logic [1:0] resp;
	logic [7:0] ra [7] = '{`TM_OFF_CTRL, `TM_OFF_GAIN, `TM_OFF_START,
		`TM_OFF_AMPL, `TM_OFF_BCL_THR, `TM_OFF_BCL_LIM, 8'h14};
	logic [31:0] rv [7] = '{`TM_RST_CTRL, `TM_RST_GAIN, `TM_RST_START,
		`TM_RST_AMPL, `TM_RST_BCL_THR, `TM_RST_BCL_LIM, 32'h100};

	tube_measure_control_loop uut (.core_clk_in, .sys_rst_in, .axi_req_in,
		.axi_rsp_out, .field_start_in, .line_start_in, .active_picture_in,
		.adc_sample_in, .adc_valid_in, .video_ctrl_out, .range_switch_one_out,
		.range_switch_one_oe_out, .range_switch_two_out, .adc_alt_select_out);
	sense_network_model sense (.core_clk_in(core_clk_in),
		.video_in(video_ctrl_out), .range_one_in(range_switch_one_out),
		.range_two_in(range_switch_two_out), .sample_out(adc_sample_in),
		.valid_out(adc_valid_in));

	initial forever #12.5 core_clk_in = ~core_clk_in;

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// Write: address and data together, response taken late
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		logic done;
		aw = 0;
		w = 0;
		done = 0;
		@(posedge core_clk_in);
		axi_req_in.awaddr <= a;
		axi_req_in.wdata <= d;
		axi_req_in.wstrb <= 4'hf;
		axi_req_in.awvalid <= 1'b1;
		axi_req_in.wvalid <= 1'b1;
		for (int n = 0; n < 64 && !done; n++) begin
			@(posedge core_clk_in);
			if (axi_req_in.bready && axi_rsp_out.bvalid === 1'b1) begin
				resp = axi_rsp_out.bresp;
				axi_req_in.bready <= 1'b0;
				done = 1;
			end else if (aw && w && axi_rsp_out.bvalid === 1'b1) begin
				axi_req_in.bready <= 1'b1;
			end
			if (!aw && axi_rsp_out.awready === 1'b1) begin
				aw = 1;
				axi_req_in.awvalid <= 1'b0;
			end
			if (!w && axi_rsp_out.wready === 1'b1) begin
				w = 1;
				axi_req_in.wvalid <= 1'b0;
			end
		end
		if (!done) chk("write_done", 1, 0);
	endtask

	// Read: address first, data taken late
	task automatic axi_rd(input logic [7:0] a);
		logic ar;
		logic done;
		ar = 0;
		done = 0;
		@(posedge core_clk_in);
		axi_req_in.araddr <= a;
		axi_req_in.arvalid <= 1'b1;
		for (int n = 0; n < 64 && !done; n++) begin
			@(posedge core_clk_in);
			if (axi_req_in.rready && axi_rsp_out.rvalid === 1'b1) begin
				rd = axi_rsp_out.rdata;
				resp = axi_rsp_out.rresp;
				axi_req_in.rready <= 1'b0;
				done = 1;
			end else if (ar && axi_rsp_out.rvalid === 1'b1) begin
				axi_req_in.rready <= 1'b1;
			end
			if (!ar && axi_rsp_out.arready === 1'b1) begin
				ar = 1;
				axi_req_in.arvalid <= 1'b0;
			end
		end
		if (!done) chk("read_done", 1, 0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d);
		chk("bresp", RESP_OKAY, resp);
	endtask

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		axi_rd(a);
		chk(n, e, rd);
	endtask

	// One field of 12 lines; blk says cutoff lines are expected
	task automatic run_field(input logic blk);
		@(posedge core_clk_in);
		field_start_in <= 1'b1;
		@(posedge core_clk_in);
		field_start_in <= 1'b0;
		for (int i = 1; i <= 12; i++) begin
			@(posedge core_clk_in);
			line_start_in <= 1'b1;
			@(posedge core_clk_in);
			line_start_in <= 1'b0;
			@(negedge core_clk_in);
			if (i == 5) begin
				chk("start_line", 1, video_ctrl_out.measure_line);
				chk("first_colour", blk ? 2'h0 : wc,
					video_ctrl_out.line_colour);
				chk("first_amp", blk ? 9'h020 : 9'h050,
					video_ctrl_out.line_amplitude);
			end
			if (i == (blk ? 8 : 5)) begin
				chk("white_line", 1, video_ctrl_out.white_line);
				chk("white_colour", wc, video_ctrl_out.line_colour);
				chk("white_amp", 9'h050, video_ctrl_out.line_amplitude);
				chk("white_range", 1, range_switch_two_out);
			end
			repeat (37) @(posedge core_clk_in);
		end
		wc = (wc == 2'h2) ? 2'h0 : wc + 2'h1;
	endtask

	task automatic t_reset;
		for (int i = 0; i < 7; i++) rdc("reset_value", ra[i], rv[i]);
		rdc("unmapped_data", 8'h70, 32'h0);
		chk("unmapped_rresp", RESP_SLVERR, resp);
		axi_wr(8'h70, 32'h1);
		chk("unmapped_bresp", RESP_SLVERR, resp);
		wr(`TM_OFF_MEAS_CUT, 32'hff);
		rdc("read_only", `TM_OFF_MEAS_CUT, 32'h0);
	endtask

	task automatic t_user;
		wr(`TM_OFF_START, 32'h5);
		wr(`TM_OFF_AMPL, 32'h01f4_3020);
		wr(`TM_OFF_CUT_SET, 32'h1ff);
		wr(`TM_OFF_CUT_SET + 8'h04, 32'h048);
		wr(`TM_OFF_CUT_SET + 8'h08, 32'h069);
		wr(`TM_OFF_WHITE_SET + 8'h04, 32'h0c3);
		repeat (3) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk("cutoff_r", 9'h1ff, video_ctrl_out.cutoff[0]);
		chk("cutoff_b", 9'h069, video_ctrl_out.cutoff[2]);
		chk("drive_g", 9'h0c3, video_ctrl_out.drive[1]);
		rdc("cut_value_g", `TM_OFF_CUT_VAL + 8'h04, 32'h048);
	endtask

	task automatic t_fields;
		run_field(1'b1);
		for (int i = 0; i < 3; i++) begin
			rdc("meas_cut", `TM_OFF_MEAS_CUT + 8'(4 * i),
				32'(16 * (i + 1)));
		end
		rdc("meas_white_r", `TM_OFF_MEAS_WHITE, 32'h090);
		run_field(1'b1);
		rdc("meas_white_g", `TM_OFF_MEAS_WHITE + 8'h04, 32'h0a0);
	endtask

	task automatic t_auto;
		wr(`TM_OFF_GAIN, 32'h4);
		run_field(1'b1);
		rdc("clamped_r", `TM_OFF_CUT_VAL, 32'h1ff);
		rdc("in_band_g", `TM_OFF_CUT_VAL + 8'h04, 32'h048);
		rdc("out_band_b", `TM_OFF_CUT_VAL + 8'h08, 32'h06d);
	endtask

	task automatic t_freeze;
		wr(`TM_OFF_WHITE_SET, 32'h1ff);
		wr(`TM_OFF_GAIN, 32'h104);
		wr(`TM_OFF_CTRL, 32'h5);
		wr(`TM_OFF_CUT_SET + 8'h08, 32'h0);
		run_field(1'b0);
		rdc("frozen_b", `TM_OFF_CUT_VAL + 8'h08, 32'h06d);
		chk("frozen_out", 9'h06d, video_ctrl_out.cutoff[2]);
		rdc("status", `TM_OFF_STATUS, 32'h101);
	endtask

	task automatic t_picture;
		wr(`TM_OFF_CTRL, 32'h8);
		@(posedge core_clk_in);
		active_picture_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk("range_one", 1, range_switch_one_out);
		chk("range_two", 1, range_switch_two_out);
		chk("alt_select", 1, adc_alt_select_out);
		chk("alt_oe", 0, range_switch_one_oe_out);
		repeat (8000) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk("contrast_min", 8'h40, video_ctrl_out.contrast);
		chk("bright_low", 8'h40, video_ctrl_out.brightness);
		axi_rd(`TM_OFF_STATUS);
		chk("beam_average", 1, rd[27:16] > 12'h800);
		@(posedge core_clk_in);
		active_picture_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk("range_off", 0, range_switch_two_out);
	endtask

	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence after a 12 cycle reset
	initial begin
		repeat (12) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		t_reset();
		t_user();
		t_fields();
		t_auto();
		t_freeze();
		t_picture();
		report_and_stop();
	end

	// Watchdog well beyond the expected 10000 cycles
	initial begin
		#(40000 * 25);
		mismatches++;
		report_and_stop();
	end
endmodule
